// ---- common/ccp_pkg.sv ----
// Package with register map, field layout and types of the compare unit
package ccp_pkg;
  // Register offsets (index = printed offset, byte address = 4 * index)
  localparam logic [7:0] CCP_IDX_FLAGS = 8'h0c;
  localparam logic [7:0] CCP_IDX_ENABLES = 8'h8c;
  localparam logic [7:0] CCP_IDX_CONTROL = 8'h17;
  localparam logic [7:0] CCP_IDX_CMP_LO = 8'h15;
  localparam logic [7:0] CCP_IDX_CMP_HI = 8'h16;
  localparam logic [7:0] CCP_IDX_TMR_LO = 8'h0e;
  localparam logic [7:0] CCP_IDX_TMR_HI = 8'h0f;
  localparam logic [7:0] CCP_IDX_STATUS = 8'h18;
  localparam int CCP_ADDR_W = 10;
  // Field positions
  localparam int CCP_BIT_T1OVF = 0;
  localparam int CCP_BIT_MATCH = 2;
  localparam logic [7:0] CCP_FLAGS_MASK = 8'h05;
  localparam logic [7:0] CCP_CTRL_MASK = 8'h3f;
  localparam logic [7:0] CCP_RESET_8 = 8'h00;
  localparam logic [15:0] CCP_RESET_16 = 16'h0000;
  localparam logic [15:0] CCP_TMR_MAX = 16'hffff;
  // Mode codes of the four mode bits
  localparam logic [3:0] CCP_M_OFF = 4'h0;
  localparam logic [3:0] CCP_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCP_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCP_M_CAP_R4 = 4'h6;
  localparam logic [3:0] CCP_M_CAP_R16 = 4'h7;
  localparam logic [3:0] CCP_M_CMP_SET = 4'h8;
  localparam logic [3:0] CCP_M_CMP_CLR = 4'h9;
  localparam logic [3:0] CCP_M_CMP_SWI = 4'ha;
  localparam logic [3:0] CCP_M_CMP_SPEC = 4'hb;
  // Prescale divide counts
  localparam logic [3:0] CCP_DIV_1 = 4'h0;
  localparam logic [3:0] CCP_DIV_4 = 4'h3;
  localparam logic [3:0] CCP_DIV_16 = 4'hf;

  // Compare and capture decoded controls
  typedef struct packed {
    logic compare_on;
    logic capture_on;
    logic pin_high;
    logic pin_low;
    logic special;
  } ccp_mode_t;

  // Match and capture events seen by the top
  typedef struct packed {
    logic match;
    logic capture;
  } ccp_event_t;
endpackage : ccp_pkg

// ---- design/ccp_compare_top.sv ----
// Compare unit with capture prescaler behind an Avalon-MM slave
//
// What this block does and how it must be used
// R1: Compare the 16-bit compare value with timer1 count every cycle in compare mode.
// R2: On match drive pin high, low, or leave it, per four mode bits.
// R3: Set the match flag in the same cycle the match acts on the pin.
// R4: Software makes port C bit 2 an output before using pin actions.
// R5: Writing zero to control forces compare latch low; port latch untouched.
// R6: Timer1 must run synchronously; asynchronous counting may miss matches.
// R7: Software interrupt mode leaves the pin; only flag and enabled interrupt.
// R8: Special event trigger clears both timer1 bytes, making a period register.
// R9: Special event trigger also issues an A/D start request.
// R10: Trigger reset of timer1 does not set the timer1 overflow flag.
// R11: Four capture prescaler settings selected by the four mode bits.
// R12: Prescaler counter cleared when unit off or not capturing, and at reset.
// R13: Switching capture settings directly keeps the prescaler count.
// R14: Software clears control before writing a new prescaler mode.
// R15: Match flag stays set until software writes it zero.
// R16: Interrupt request only when a flag (match or timer1 overflow) and its enable are both set.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module ccp_compare_top
  import ccp_pkg::*;
#(
  parameter int TMR_W = 16
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [CCP_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Timer1 tick and capture input
  input wire logic timer1_tick_in,
  input wire logic capture_edge_in,
  // Pin, trigger and interrupt
  output logic compare_output_pin_out,
  output logic adc_start_out,
  output logic irq_out
);
  // Only a 16-bit timer is served
  if (TMR_W != 16) begin : g_bad_width
    $error("TMR_W must be 16");
  end

  logic [7:0] unit_control;
  logic [15:0] compare_value;
  logic [15:0] timer1_count;
  logic match_flag;
  logic timer1_overflow_flag;
  logic match_irq_enable;
  logic timer1_irq_enable;
  logic [7:0] enables_rest;
  logic pin_latch;
  logic acked;

  // Bus decode
  wire [7:0] idx = avs_address_in[CCP_ADDR_W-1:2];
  wire req = (avs_read_in || avs_write_in) && !acked;
  wire wr = avs_write_in && !acked && avs_byteenable_in[0];
  wire [7:0] wd = avs_writedata_in[7:0];
  wire wr_flags = wr && idx == CCP_IDX_FLAGS;
  wire wr_en = wr && idx == CCP_IDX_ENABLES;
  wire wr_ctrl = wr && idx == CCP_IDX_CONTROL;
  wire wr_clo = wr && idx == CCP_IDX_CMP_LO;
  wire wr_chi = wr && idx == CCP_IDX_CMP_HI;
  wire wr_tlo = wr && idx == CCP_IDX_TMR_LO;
  wire wr_thi = wr && idx == CCP_IDX_TMR_HI;

  // Mode decode
  wire [3:0] unit_mode_bits = unit_control[3:0];
  ccp_mode_t mode;
  assign mode.compare_on = unit_mode_bits[3];
  assign mode.capture_on = (unit_mode_bits >= CCP_M_CAP_FALL) &&
                           (unit_mode_bits <= CCP_M_CAP_R16); // [R11]
  assign mode.pin_high = unit_mode_bits == CCP_M_CMP_SET;
  assign mode.pin_low = unit_mode_bits == CCP_M_CMP_CLR;
  assign mode.special = unit_mode_bits == CCP_M_CMP_SPEC;

  // Continuous compare [R1]
  ccp_event_t ev;
  assign ev.match = mode.compare_on && (compare_value == timer1_count);

  // Capture prescaler [R11] [R12] [R13]
  logic [3:0] presc_count;
  ccp_prescaler u_presc (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .unit_mode_bits_in(unit_mode_bits),
    .edge_in(capture_edge_in),
    .capture_out(ev.capture),
    .count_out(presc_count)
  );

  wire special_hit = ev.match && mode.special; // [R8]
  wire t1_wrap = timer1_tick_in && timer1_count == CCP_TMR_MAX;
  wire match_set = ev.match || ev.capture;
  // Set wins over a software clear [R15]
  wire next_match_flag = match_set ||
    (wr_flags ? wd[CCP_BIT_MATCH] : match_flag);
  // Trigger reset never counts as overflow [R10]
  wire next_t1_flag = (t1_wrap && !special_hit) ||
    (wr_flags ? wd[CCP_BIT_T1OVF] : timer1_overflow_flag);
  wire [15:0] next_timer = special_hit ? CCP_RESET_16 :
    wr_tlo ? {timer1_count[15:8], wd} :
    wr_thi ? {wd, timer1_count[7:0]} :
    timer1_tick_in ? timer1_count + 16'h0001 : timer1_count;
  // Pin action; SWI and trigger modes leave the pin [R2] [R7]
  wire next_pin_latch = (wr_ctrl && wd == CCP_RESET_8) ? 1'b0 : // [R5]
    (ev.match && mode.pin_high) ? 1'b1 :
    (ev.match && mode.pin_low) ? 1'b0 : pin_latch;
  wire next_match_irq_enable = wr_en ? wd[CCP_BIT_MATCH] : match_irq_enable;
  wire next_t1_irq_enable = wr_en ? wd[CCP_BIT_T1OVF] : timer1_irq_enable;
  wire next_irq = (next_match_flag && next_match_irq_enable) ||
    (next_t1_flag && next_t1_irq_enable); // [R16]

  // Read mux
  wire [7:0] flags_rd = {5'b0, match_flag, 1'b0, timer1_overflow_flag};
  wire [7:0] en_rd = enables_rest | {5'b0, match_irq_enable, 1'b0,
    timer1_irq_enable};
  wire [7:0] rd8 =
    idx == CCP_IDX_FLAGS ? flags_rd :
    idx == CCP_IDX_ENABLES ? en_rd :
    idx == CCP_IDX_CONTROL ? unit_control :
    idx == CCP_IDX_CMP_LO ? compare_value[7:0] :
    idx == CCP_IDX_CMP_HI ? compare_value[15:8] :
    idx == CCP_IDX_TMR_LO ? timer1_count[7:0] :
    idx == CCP_IDX_TMR_HI ? timer1_count[15:8] :
    idx == CCP_IDX_STATUS ? {3'b0, pin_latch, presc_count} :
    CCP_RESET_8;

  // Bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acked <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      acked <= req;
      avs_waitrequest_out <= !req;
      avs_readdata_out <= {24'h00_0000, rd8};
    end
  end

  // Control and compare value
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      unit_control <= CCP_RESET_8;
      compare_value <= CCP_RESET_16;
    end else begin
      if (wr_ctrl) unit_control <= wd & CCP_CTRL_MASK;
      if (wr_clo) compare_value[7:0] <= wd;
      if (wr_chi) compare_value[15:8] <= wd;
    end
  end

  // Enables
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      enables_rest <= CCP_RESET_8;
      match_irq_enable <= 1'b0;
      timer1_irq_enable <= 1'b0;
    end else begin
      if (wr_en) enables_rest <= wd & ~CCP_FLAGS_MASK;
      match_irq_enable <= next_match_irq_enable;
      timer1_irq_enable <= next_t1_irq_enable;
    end
  end

  // Timer1 count
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer1_count <= CCP_RESET_16;
    end else begin
      timer1_count <= next_timer; // [R8]
    end
  end

  // Flags
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      match_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      match_flag <= next_match_flag; // [R3] [R15]
      timer1_overflow_flag <= next_t1_flag; // [R10]
    end
  end

  // Pin, trigger and interrupt outputs
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_latch <= 1'b0;
      compare_output_pin_out <= 1'b0;
      adc_start_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      pin_latch <= next_pin_latch; // [R2]
      compare_output_pin_out <= next_pin_latch; // [R3]
      adc_start_out <= special_hit; // [R9]
      irq_out <= next_irq; // [R16]
    end
  end

  AST_MATCH_FLAG: assert property (@(posedge clock_in) // [R3]
    disable iff (!nrst_in)
    ev.match |=> match_flag)
    else $error("match did not set flag");
  AST_PIN_HIGH: assert property (@(posedge clock_in) // [R2]
    disable iff (!nrst_in)
    ev.match && mode.pin_high && !wr_ctrl |=> compare_output_pin_out)
    else $error("pin not driven high on match");
  AST_PIN_LOW: assert property (@(posedge clock_in) // [R2]
    disable iff (!nrst_in)
    ev.match && mode.pin_low |=> !compare_output_pin_out)
    else $error("pin not driven low on match");
  AST_SWI_PIN: assert property (@(posedge clock_in) // [R7]
    disable iff (!nrst_in)
    ev.match && unit_mode_bits == CCP_M_CMP_SWI && !wr_ctrl
    |=> $stable(compare_output_pin_out))
    else $error("software interrupt mode moved pin");
  AST_CTRL_ZERO: assert property (@(posedge clock_in) // [R5]
    disable iff (!nrst_in)
    wr_ctrl && wd == CCP_RESET_8 |=> !compare_output_pin_out)
    else $error("clearing control did not force pin low");
  AST_SPECIAL: assert property (@(posedge clock_in) // [R8] [R9]
    disable iff (!nrst_in)
    special_hit |=> timer1_count == CCP_RESET_16 && adc_start_out)
    else $error("special trigger missed timer clear or adc start");
  AST_NO_T1OVF: assert property (@(posedge clock_in) // [R10]
    disable iff (!nrst_in)
    special_hit && !timer1_overflow_flag && !wr_flags
    |=> !timer1_overflow_flag)
    else $error("trigger set timer1 overflow flag");
  AST_FLAG_STICKY: assert property (@(posedge clock_in) // [R15]
    disable iff (!nrst_in)
    match_flag && !wr_flags |=> match_flag)
    else $error("match flag dropped without clear");
  AST_IRQ: assert property (@(posedge clock_in) // [R16]
    disable iff (!nrst_in)
    irq_out |-> (match_flag && match_irq_enable) ||
    (timer1_overflow_flag && timer1_irq_enable))
    else $error("irq without enabled flag");
  AST_NO_MATCH_OFF: assert property (@(posedge clock_in) // [R1]
    disable iff (!nrst_in)
    !mode.compare_on && !ev.capture && !match_flag &&
    !(wr_flags && wd[CCP_BIT_MATCH]) |=> !match_flag)
    else $error("flag set while compare is off");
  AST_TIMER_STEP: assert property (@(posedge clock_in) // [R1]
    disable iff (!nrst_in)
    timer1_tick_in && !special_hit && !wr_tlo && !wr_thi
    |=> timer1_count == $past(timer1_count) + 16'h0001)
    else $error("timer1 did not step on tick");
  AST_PIN_IDLE: assert property (@(posedge clock_in) // [R2]
    disable iff (!nrst_in)
    !ev.match && !(wr_ctrl && wd == CCP_RESET_8)
    |=> $stable(compare_output_pin_out))
    else $error("pin moved without a match");
  AST_SPECIAL_PIN: assert property (@(posedge clock_in) // [R2]
    disable iff (!nrst_in)
    special_hit && !wr_ctrl |=> $stable(compare_output_pin_out))
    else $error("trigger mode moved pin");
  AST_NO_ADC: assert property (@(posedge clock_in) // [R9]
    disable iff (!nrst_in)
    !special_hit |=> !adc_start_out)
    else $error("adc start without special trigger");
  AST_T1_WRAP: assert property (@(posedge clock_in) // [R10]
    disable iff (!nrst_in)
    t1_wrap && !special_hit && !wr_tlo && !wr_thi
    |=> timer1_overflow_flag && timer1_count == CCP_RESET_16)
    else $error("timer1 wrap missed overflow flag");
  AST_PERIOD: assert property (@(posedge clock_in) // [R8]
    disable iff (!nrst_in)
    special_hit |=> !special_hit || compare_value == CCP_RESET_16)
    else $error("special trigger repeated without period");
  AST_IRQ_ON: assert property (@(posedge clock_in) // [R16]
    disable iff (!nrst_in)
    match_flag && match_irq_enable && !wr_en && !wr_flags |=> irq_out)
    else $error("enabled match flag gave no irq");
  AST_IRQ_EXACT: assert property (@(posedge clock_in) // [R16]
    disable iff (!nrst_in)
    irq_out == ((match_flag && match_irq_enable) ||
    (timer1_overflow_flag && timer1_irq_enable)))
    else $error("irq does not follow enabled flags");
  AST_SWI_IRQ: assert property (@(posedge clock_in) // [R7]
    disable iff (!nrst_in)
    ev.match && unit_mode_bits == CCP_M_CMP_SWI && match_irq_enable &&
    !wr_en |=> irq_out)
    else $error("software interrupt mode gave no irq");
  AST_PRESC_KEEP: assert property (@(posedge clock_in) // [R13]
    disable iff (!nrst_in)
    mode.capture_on && !capture_edge_in |=> $stable(presc_count))
    else $error("prescaler count moved without an edge");
  AST_CAPTURE_FLAG: assert property (@(posedge clock_in) // [R11]
    disable iff (!nrst_in)
    ev.capture |=> match_flag)
    else $error("capture did not set flag");
  AST_DIV4_WRAP: assert property (@(posedge clock_in) // [R11]
    disable iff (!nrst_in)
    unit_mode_bits == CCP_M_CAP_R4 && capture_edge_in &&
    presc_count == CCP_DIV_4 |=> ev.capture && presc_count == 4'h0)
    else $error("divide by four did not wrap");
  AST_CTRL_ZERO_PRESC: assert property (@(posedge clock_in) // [R12]
    disable iff (!nrst_in)
    wr_ctrl && wd == CCP_RESET_8 |-> ##2 presc_count == 4'h0)
    else $error("clearing control left prescaler count");
  AST_FLAG_CLEAR: assert property (@(posedge clock_in) // [R15]
    disable iff (!nrst_in)
    wr_flags && !wd[CCP_BIT_MATCH] && !match_set |=> !match_flag)
    else $error("software clear of match flag lost");
endmodule : ccp_compare_top

// ---- design/ccp_prescaler.sv ----
// Capture prescaler: counts capture edges, pulses on every Nth
`timescale 1ns/1ps
module ccp_prescaler
  import ccp_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Control
  input wire logic [3:0] unit_mode_bits_in,
  input wire logic edge_in,
  // Result
  output logic capture_out,
  output logic [3:0] count_out
);
  logic [3:0] count;
  logic [3:0] limit;
  logic capture_mode;
  logic wrap;

  assign capture_mode = (unit_mode_bits_in >= CCP_M_CAP_FALL) &&
                        (unit_mode_bits_in <= CCP_M_CAP_R16);
  assign limit = (unit_mode_bits_in == CCP_M_CAP_R16) ? CCP_DIV_16 :
                 (unit_mode_bits_in == CCP_M_CAP_R4) ? CCP_DIV_4 :
                 CCP_DIV_1;
  // Counter is not reset when one capture setting replaces another [R13]
  assign wrap = (count >= limit);

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 4'h0;
      capture_out <= 1'b0;
    end else if (!capture_mode) begin
      count <= 4'h0; // [R12]
      capture_out <= 1'b0;
    end else begin
      capture_out <= edge_in && wrap;
      if (edge_in) begin
        count <= wrap ? 4'h0 : count + 4'h1;
      end
    end
  end

  assign count_out = count;

  AST_PRESC_CLEAR: assert property (@(posedge clock_in) // [R12]
    disable iff (!nrst_in)
    !capture_mode |=> count == 4'h0)
    else $error("prescaler not cleared outside capture");
endmodule : ccp_prescaler

// ---- sim/ccp_far_model.sv ----
// Far-side model: Timer1 tick source and A/D start counter
`timescale 1ns/1ps
module ccp_far_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Requests from the bench
  input wire logic go_in,
  input wire logic fast_in,
  input wire logic [7:0] ticks_in,
  // From the block
  input wire logic adc_start_in,
  // To the block and the bench
  output logic tick_out,
  output logic done_out,
  output logic [7:0] adc_count_out
);
  logic [7:0] left;
  assign done_out = (left == 8'h00) && !tick_out;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      left <= 8'h00;
      tick_out <= 1'b0;
      adc_count_out <= 8'h00;
    end else begin
      if (adc_start_in) adc_count_out <= adc_count_out + 8'h01;
      // Ticks come on this clock only, so Timer1 stays synchronous
      if (go_in) begin
        left <= ticks_in;
        tick_out <= 1'b0;
      end else if (left != 8'h00 && (fast_in || !tick_out)) begin
        tick_out <= 1'b1;
        left <= left - 8'h01;
      end else begin
        tick_out <= 1'b0;
      end
    end
  end
endmodule : ccp_far_model

// ---- sim/test_ccp_compare_top.sv ----
// Self-checking bench of the compare unit and capture prescaler
`timescale 1ns/1ps
module test_ccp_compare_top;
  import ccp_pkg::*;
  logic clock_in, nrst_in, avs_read_in, avs_write_in, capture_edge_in;
  logic go, fast, done, tick, pin, adc, irq, avs_waitrequest_out;
  logic [CCP_ADDR_W-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [7:0] ticks, adc_count, v;
  logic [31:0] expq[$];
  int n_fail, checks;
  ccp_compare_top dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'h1), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .timer1_tick_in(tick),
    .capture_edge_in(capture_edge_in), .compare_output_pin_out(pin),
    .adc_start_out(adc), .irq_out(irq));
  ccp_far_model far (.clock_in(clock_in), .nrst_in(nrst_in), .go_in(go),
    .fast_in(fast), .ticks_in(ticks), .adc_start_in(adc), .tick_out(tick),
    .done_out(done), .adc_count_out(adc_count));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task ack();
    do @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0);
  endtask : ack
  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock_in);
    avs_address_in <= {idx, 2'b00};
    avs_writedata_in <= {24'h00_0000, d};
    avs_write_in <= 1'b1;
    ack();
    avs_write_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] idx, input logic [7:0] e);
    expq.push_back({24'h00_0000, e});
    @(posedge clock_in);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= 1'b1;
    ack();
    avs_read_in <= 1'b0;
  endtask : rd
  // Read data compared against the oldest note at the answering edge
  always @(posedge clock_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0 && expq.size() > 0)
      check(avs_readdata_out, expq.pop_front());
  end
  task run(input logic [3:0] m, input logic f);
    v = 8'(3 + $urandom % 60);
    wr(CCP_IDX_TMR_LO, 8'h00);
    wr(CCP_IDX_TMR_HI, 8'h12);
    wr(CCP_IDX_CMP_LO, v);
    wr(CCP_IDX_CMP_HI, 8'h12);
    wr(CCP_IDX_CONTROL, {4'h0, m});
    wr(CCP_IDX_FLAGS, 8'h00);
    @(posedge clock_in);
    go <= 1'b1;
    ticks <= v;
    fast <= f;
    @(posedge clock_in);
    go <= 1'b0;
    do @(posedge clock_in);
    while (done !== 1'b1);
    repeat (3) @(posedge clock_in);
  endtask : run
  task edges(input int n);
    repeat (n) begin
      @(posedge clock_in);
      capture_edge_in <= 1'b1;
      @(posedge clock_in);
      capture_edge_in <= 1'b0;
    end
  endtask : edges
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  initial begin
    #100_000;
    n_fail++;
    conclude();
  end
  initial begin
    {nrst_in, avs_read_in, avs_write_in, capture_edge_in, go, fast} = 6'h00;
    avs_address_in = '0;
    avs_writedata_in = 32'h0000_0000;
    ticks = 8'h00;
    n_fail = 0;
    checks = 0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    v = 8'($urandom(32'h0d78));
    rd(CCP_IDX_FLAGS, CCP_RESET_8);
    rd(CCP_IDX_ENABLES, CCP_RESET_8);
    rd(CCP_IDX_STATUS, CCP_RESET_8);
    rd(8'h3f, 8'h00);
    $display("test reset done");
    wr(CCP_IDX_ENABLES, 8'h04);
    // Software has made the compare pin an output from here on
    run(CCP_M_CMP_SET, 1'b0);
    check(pin, 1'b1);
    check(irq, 1'b1);
    rd(CCP_IDX_FLAGS, 8'h04);
    wr(CCP_IDX_ENABLES, 8'h00);
    @(posedge clock_in);
    @(posedge clock_in);
    check(irq, 1'b0);
    run(CCP_M_CMP_CLR, 1'b1);
    check(pin, 1'b0);
    run(CCP_M_CMP_SET, 1'b1);
    wr(CCP_IDX_CONTROL, 8'h00);
    @(posedge clock_in);
    @(posedge clock_in);
    check(pin, 1'b0);
    $display("test pin actions done");
    run(CCP_M_CMP_SET, 1'b1);
    run(CCP_M_CMP_SWI, 1'b0);
    check(pin, 1'b1);
    wr(CCP_IDX_CONTROL, 8'h00);
    rd(CCP_IDX_FLAGS, 8'h04);
    wr(CCP_IDX_FLAGS, 8'h00);
    rd(CCP_IDX_FLAGS, 8'h00);
    run(CCP_M_CMP_SPEC, 1'b1);
    check(adc_count, 8'h01);
    rd(CCP_IDX_TMR_LO, 8'h00);
    rd(CCP_IDX_TMR_HI, 8'h00);
    rd(CCP_IDX_FLAGS, 8'h04);
    $display("test interrupt and trigger modes done");
    wr(CCP_IDX_CONTROL, {4'h0, CCP_M_CAP_R4});
    edges(2);
    rd(CCP_IDX_STATUS, 8'h02);
    wr(CCP_IDX_CONTROL, {4'h0, CCP_M_CAP_R16});
    rd(CCP_IDX_STATUS, 8'h02);
    wr(CCP_IDX_CONTROL, 8'h00);
    rd(CCP_IDX_STATUS, 8'h00);
    wr(CCP_IDX_FLAGS, 8'h00);
    wr(CCP_IDX_CONTROL, {4'h0, CCP_M_CAP_R4});
    edges(4);
    rd(CCP_IDX_FLAGS, 8'h04);
    wr(CCP_IDX_CONTROL, 8'h00);
    wr(CCP_IDX_FLAGS, 8'h00);
    wr(CCP_IDX_CONTROL, {4'h0, CCP_M_CAP_RISE});
    edges(1);
    rd(CCP_IDX_FLAGS, 8'h04);
    $display("test prescaler done");
    conclude();
  end
endmodule : test_ccp_compare_top
